// file: sim/iaa_arbiter_properties.sv
// Concurrent checks on the arbiter's CPU-side and write-response ports.
// Assumes it is bound into iaa_arbiter; one clock, sync active-low reset.
module iaa_arbiter_properties
  import iaa_pkg::*;
(
  input wire logic         aclk,
  input wire logic         aresetn,
  input wire logic         s_axi_bvalid,
  input wire logic         s_axi_bready,
  input wire logic [1:0]   s_axi_bresp,
  input wire logic         nmi_pin,
  input wire logic         cpu_decode,
  input wire logic [31:0]  program_counter,
  input wire logic [31:0]  cpu_stack_ptr,
  input wire iaa_mem_req_t mem_req,
  input wire logic         mem_ready,
  input wire logic [31:0]  mem_rdata,
  input wire logic         cpu_request_out_pin_n,
  input wire logic         entry_branch,
  input wire logic [31:0]  handler_addr,
  input wire logic [31:0]  stack_ptr_out,
  input wire logic [31:0]  cpu_status_word
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       nmi_q;
  logic [3:0] nmi_age;
  wire        sr_push = mem_req.valid && mem_req.write && mem_req.addr == cpu_stack_ptr - 32'h4;
  wire        pc_push = mem_req.valid && mem_req.write && mem_req.addr == cpu_stack_ptr - 32'h8;
  wire        vec_rd  = mem_req.valid && !mem_req.write;

  // ==========================================================
  // Cycles since the nonmaskable input last moved, saturating
  always_ff @(posedge aclk)
  begin
    nmi_q <= nmi_pin;
    if (!aresetn)
      nmi_age <= 4'hf;
    else if (nmi_pin != nmi_q)
      nmi_age <= 4'h0;
    else if (nmi_age != 4'hf)
      nmi_age <= nmi_age + 4'h1;
  end

  // ==========================================================
  // Properties
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_reset_idle: assert property ($rose(aresetn) |-> cpu_request_out_pin_n && !mem_req.valid
    && cpu_status_word == STATUS_RESET) else $error("request pin or status not idle after reset");
  chk_sr_first: assert property ($rose(mem_req.valid) |-> sr_push && $past(cpu_decode, 2)
    && mem_req.wdata == cpu_status_word) else $error("entry did not start with status push");
  chk_pc_second: assert property (sr_push && mem_ready |=> pc_push
    && mem_req.wdata == program_counter) else $error("program counter push missing");
  chk_vec_third: assert property (pc_push && mem_ready |=> vec_rd)
    else $error("vector read does not follow stacking");
  chk_req_held: assert property (mem_req.valid && !mem_ready |=> $stable(mem_req))
    else $error("memory request changed before ready");
  chk_branch_now: assert property (vec_rd && mem_ready |=> entry_branch
    && handler_addr == $past(mem_rdata)) else $error("branch not taken at vector data");
  chk_branch_pulse: assert property (entry_branch |=> !entry_branch
    && stack_ptr_out == cpu_stack_ptr - 32'h8) else $error("branch pulse or stack pointer wrong");
  chk_nmi_only: assert property ($fell(cpu_request_out_pin_n) && cpu_status_word[7:4] == TOP_MASK
    |-> nmi_age < 4'h9) else $error("request accepted at top mask without nonmaskable edge");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");

  cover property (entry_branch);
  cover property ($fell(cpu_request_out_pin_n));
  cover property (vec_rd && mem_ready);
endmodule

// file: sim/iaa_cpu_mem.sv
// CPU-side model: stack and vector memory answering the arbiter's requests.
// Assumes mem_req holds until mem_ready; wait_n sets the answer delay.
module iaa_cpu_mem
  import iaa_pkg::*;
(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire iaa_mem_req_t mem_req,
  input  wire logic [3:0]   wait_n,
  output logic              mem_ready,
  output logic [31:0]       mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0]  cnt;
  logic        wr_idx;
  logic [31:0] wr_addr [2];
  logic [31:0] wr_data [2];
  logic [31:0] rd_addr;
  wire         take = mem_req.valid && !mem_ready && cnt == wait_n;

  // ==========================================================
  // Responder
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt <= 4'h0;
      wr_idx <= 1'b0;
      mem_ready <= 1'b0;
      mem_rdata <= 32'h0;
    end
    else if (take)
    begin
      mem_ready <= 1'b1;
      cnt <= 4'h0;
      mem_rdata <= mem_req.addr ^ 32'h5a5a0000;
      if (mem_req.write)
      begin
        wr_addr[wr_idx] <= mem_req.addr;
        wr_data[wr_idx] <= mem_req.wdata;
        wr_idx <= !wr_idx;
      end
      else
        rd_addr <= mem_req.addr;
    end
    else
    begin
      mem_ready <= 1'b0;
      cnt <= (mem_req.valid && !mem_ready) ? cnt + 4'h1 : 4'h0;
      // Stale data inverted so nothing leans on a held value
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

// file: sim/tb.sv
// Self-checking bench for the interrupt accept arbiter.
// Assumes the package, arbiter, checker and CPU-side model are compiled first.
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; \
  $display("[ERR] %0t got %0h exp %0h", $time, a, b); end end
module tb
  import iaa_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic               aclk;
  logic               aresetn = 1'b0;
  logic [7:0]         s_axi_awaddr = 8'h00;
  logic               s_axi_awvalid = 1'b0;
  logic               s_axi_awready;
  logic [31:0]        s_axi_wdata = 32'h0;
  logic [3:0]         s_axi_wstrb = 4'hf;
  logic               s_axi_wvalid = 1'b0;
  logic               s_axi_wready;
  logic [1:0]         s_axi_bresp;
  logic               s_axi_bvalid;
  logic               s_axi_bready = 1'b0;
  logic [7:0]         s_axi_araddr = 8'h00;
  logic               s_axi_arvalid = 1'b0;
  logic               s_axi_arready;
  logic [31:0]        s_axi_rdata;
  logic [1:0]         s_axi_rresp;
  logic               s_axi_rvalid;
  logic               s_axi_rready = 1'b0;
  logic [IRQ_N-1:0]   irq_pin_n = 8'hff;
  logic               nmi_pin = 1'b1;
  logic [MOD_N-1:0]   module_req = 15'h0;
  logic               cpu_decode = 1'b0;
  logic [31:0]        program_counter = 32'h00000200;
  logic [31:0]        cpu_stack_ptr = 32'h00001000;
  logic [31:0]        cpu_vector_base = 32'h00008000;
  iaa_mem_req_t       mem_req;
  logic               mem_ready;
  logic [31:0]        mem_rdata;
  logic               cpu_request_out_pin_n;
  logic               entry_branch;
  logic [31:0]        handler_addr;
  logic [31:0]        stack_ptr_out;
  logic [31:0]        cpu_status_word;
  logic [3:0]         wait_n = 4'h0;
  logic [31:0]        sr = STATUS_RESET;
  int                 miscompares = 0;
  int                 checks = 0;

  iaa_arbiter dut (.*);
  iaa_cpu_mem cpu (.aclk, .aresetn, .mem_req, .wait_n, .mem_ready, .mem_rdata);

  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // ==========================================================
  // Reporting
  task results;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task tmo;
    miscompares++;
    $display("[ERR] %0t got %0h exp %0h", $time, 1'b0, 1'b1);
    results();
  endtask

  // ==========================================================
  // Bus and CPU helpers
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
        break;
    end
    s_axi_bready <= 1'b0;
    if (n == 40)
      tmo();
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
        break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n == 40)
      tmo();
  endtask

  task automatic set_mask(input logic [3:0] m);
    sr = {24'h0, m, 4'h0};
    wr(OFS_STATUS, sr);
  endtask

  task automatic wait_pin(input logic v, input int lim);
    int n;
    for (n = 0; n < lim && cpu_request_out_pin_n !== v; n++)
      @(posedge aclk);
    if (n == lim)
      tmo();
    `CHK(cpu_request_out_pin_n, v)
  endtask

  // Decode one instruction and follow the whole entry sequence
  task automatic entry(input logic [7:0] vec, input logic [3:0] lvl);
    int n;
    logic [31:0] va;
    va = cpu_vector_base + {22'h0, vec, 2'b00};
    @(posedge aclk);
    cpu_decode <= 1'b1;
    @(posedge aclk);
    cpu_decode <= 1'b0;
    for (n = 0; n < 80 && entry_branch !== 1'b1; n++)
      @(posedge aclk);
    if (n == 80)
      tmo();
    `CHK(cpu.wr_addr[0], cpu_stack_ptr - 32'h4)
    `CHK(cpu.wr_data[0], sr)
    `CHK(cpu.wr_addr[1], cpu_stack_ptr - 32'h8)
    `CHK(cpu.wr_data[1], program_counter)
    `CHK(cpu.rd_addr, va)
    `CHK(handler_addr, va ^ 32'h5a5a0000)
    `CHK(cpu_status_word, {24'h0, lvl, 4'h0})
    sr = {24'h0, lvl, 4'h0};
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0]  r;
    `CHK(cpu_request_out_pin_n, 1'b1)
    rd(OFS_STATUS, d, r);
    `CHK(d, STATUS_RESET)
    rd(OFS_SENSE, d, r);
    `CHK(d[15:0], 16'h8000)
    rd(OFS_ACCEPT + 8'h4, d, r);
    `CHK(r, RESP_DECERR)
    `CHK(d, 32'h0)
  endtask

  task automatic t_module;
    wr(OFS_LEVEL_A + 8'h8, 32'h8900);
    set_mask(4'h8);
    @(posedge aclk);
    module_req <= 15'h0003;
    repeat (6) @(posedge aclk);
    `CHK(cpu_request_out_pin_n, 1'b1)
    module_req <= 15'h000f;
    @(posedge aclk);
    #1 `CHK(cpu_request_out_pin_n, 1'b1)
    @(posedge aclk);
    #1 `CHK(cpu_request_out_pin_n, 1'b0)
    entry(MOD_VECTOR + 8'h2, 4'h9);
    wait_pin(1'b1, 10);
    set_mask(4'h0);
    wait_pin(1'b0, 10);
    module_req <= 15'h0;
    wait_pin(1'b1, 10);
  endtask

  task automatic t_pins;
    wait_n <= 4'h3;
    wr(OFS_LEVEL_A, 32'h7300);
    wr(OFS_SENSE, 32'h0080);
    wr(OFS_PINFUNC, 32'h03);
    repeat (3)
    begin
      @(posedge aclk);
      irq_pin_n[0] <= 1'b0;
      repeat (4) @(posedge aclk);
      irq_pin_n[0] <= 1'b1;
      repeat (4) @(posedge aclk);
    end
    wait_pin(1'b0, 12);
    entry(IRQ_VECTOR, 4'h7);
    `CHK(cpu_request_out_pin_n, 1'b1)
    set_mask(4'h0);
    repeat (8) @(posedge aclk);
    `CHK(cpu_request_out_pin_n, 1'b1)
    irq_pin_n[1] <= 1'b0;
    wait_pin(1'b0, 12);
    irq_pin_n[1] <= 1'b1;
    wait_pin(1'b1, 12);
    wr(OFS_LEVEL_A, 32'h7320);
    irq_pin_n[2] <= 1'b0;
    wr(OFS_SENSE, 32'h00a0);
    wr(OFS_PINFUNC, 32'h07);
    wait_pin(1'b0, 12);
    entry(IRQ_VECTOR + 8'h2, 4'h2);
    irq_pin_n[2] <= 1'b1;
  endtask

  task automatic t_nmi;
    set_mask(4'hf);
    nmi_pin <= 1'b0;
    wait_pin(1'b0, 12);
    entry(NMI_VECTOR, 4'hf);
    nmi_pin <= 1'b1;
    repeat (8) @(posedge aclk);
    `CHK(cpu_request_out_pin_n, 1'b1)
  endtask

  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_module();
    t_pins();
    t_nmi();
    results();
  end
endmodule

bind iaa_arbiter iaa_arbiter_properties u_props (.*);

// file: verilog/iaa_arbiter.sv
// Interrupt accept arbiter: pin and on-chip request gathering, priority
// selection, mask compare, request pin and CPU exception entry sequencer.
// Assumes module requests are on aclk; pins are asynchronous.

// Overview of operation
// [R1] Highest programmed level wins each round
// [R2] Ties resolved by fixed default source order
// [R3] Accept only when level exceeds mask
// [R4] Acceptance drives request pin low
// [R5] Pin equals internal CPU request line
// [R6] CPU samples request at instruction decode
// [R7] Push status word then PC, longwords
// [R8] Load accepted level into mask field
// [R9] Level and on-chip requests release after acceptance
// [R10] Edge requests release when instruction replaced
// [R11] Higher accepted request keeps pin low
// [R12] Read vector entry, branch without delay
// [R13] Edge request latched once, not queued
// [R14] Level request pending only while asserted
// [R15] On-chip requests are held levels
// [R16] Select and compare: 2 or 3 states
// [R17] Request waits for current sequence end
// [R18] Entry: fixed states plus three accesses
// [R19] Low pin switched in edge mode requests
// [R20] Software switches pin function while high
// [R21] Four-bit fields, 0 lowest, F highest
// [R22] Shared field gives both modules one level
// [R23] Sense bit: 0 level, 1 falling edge
// [R24] Nonmaskable edge bit: 0 falling, 1 rising
// [R25] Reset: no pending edges, pin high
module iaa_arbiter
  import iaa_pkg::*;
(
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  input  wire logic [IRQ_N-1:0]   irq_pin_n,
  input  wire logic               nmi_pin,
  input  wire logic [MOD_N-1:0]   module_req,
  input  wire logic               cpu_decode,
  input  wire logic [31:0]        program_counter,
  input  wire logic [31:0]        cpu_stack_ptr,
  input  wire logic [31:0]        cpu_vector_base,
  output iaa_mem_req_t            mem_req,
  input  wire logic               mem_ready,
  input  wire logic [31:0]        mem_rdata,
  output logic                    cpu_request_out_pin_n,
  output logic                    entry_branch,
  output logic [31:0]             handler_addr,
  output logic [31:0]             stack_ptr_out,
  output logic [31:0]             cpu_status_word
);

  // ==========================================================
  // Registers
  logic [15:0]      source_level_regs [5];
  logic [15:0]      pin_sense_control_reg;
  logic [7:0]       pin_function_selector;
  iaa_state_t       state;
  iaa_accept_t      acc;
  iaa_accept_t      cand;

  function automatic logic [3:0] field_level(input logic [4:0] f);
    logic [15:0] r;
    r = source_level_regs[f[4:2]];
    unique case (f[1:0])
      2'd0: field_level = r[15:12];
      2'd1: field_level = r[11:8];
      2'd2: field_level = r[7:4];
      default: field_level = r[3:0];
    endcase
  endfunction

  // ==========================================================
  // Pin synchronisers
  logic [IRQ_N-1:0] irq_s1;
  logic [IRQ_N-1:0] irq_s2;
  logic [IRQ_N-1:0] irq_q;
  logic [IRQ_N-1:0] irq_qq;
  logic             nmi_s1;
  logic             nmi_s2;
  logic             nmi_q;

  always_ff @(posedge aclk)
  begin
    irq_s1 <= irq_pin_n;
    irq_s2 <= irq_s1;
    nmi_s1 <= nmi_pin;
    nmi_s2 <= nmi_s1;
  end

  // Pin not yet routed to the controller looks idle high
  wire [IRQ_N-1:0] irq_seen = irq_s2 | ~pin_function_selector; // [R19]

  // ==========================================================
  // Pending state
  logic [IRQ_N-1:0] irq_pend;
  logic             nmi_pend;
  logic [MOD_N-1:0] mod_q;

  wire              nmi_edge_sel = pin_sense_control_reg[NMI_EDGE_BIT];
  wire              nmi_rise     = nmi_s2 & ~nmi_q;
  wire              nmi_fall     = ~nmi_s2 & nmi_q;
  wire              nmi_event    = nmi_edge_sel ? nmi_rise : nmi_fall; // [R24]
  wire              replacing    = (state == IAA_REPLACE);
  wire              clear_nmi    = replacing && acc.edge_sensed && (acc.idx == 5'd0);

  // Pin n sense bit sits at bit 7-n
  wire [IRQ_N-1:0]  sense_edge;
  wire [IRQ_N-1:0]  irq_fall = irq_qq & ~irq_q;

  genvar gi;
  generate
    for (gi = 0; gi < IRQ_N; gi++)
    begin : g_pin
      assign sense_edge[gi] = pin_sense_control_reg[IRQ_N-1-gi];
      wire clr = replacing && acc.edge_sensed && (acc.idx == 5'(gi + 1));
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          irq_pend[gi] <= 1'b0; // [R25]
        else if (!sense_edge[gi])
          irq_pend[gi] <= ~irq_q[gi]; // [R14] [R23]
        else if (irq_fall[gi])
          irq_pend[gi] <= 1'b1; // [R13] set wins over clear
        else if (clr)
          irq_pend[gi] <= 1'b0; // [R10]
      end
    end
  endgenerate

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_q    <= '1;
      irq_qq   <= '1;
      nmi_q    <= 1'b1;
      nmi_pend <= 1'b0; // [R25]
      mod_q    <= '0;
    end
    else
    begin
      irq_q    <= irq_seen;
      irq_qq   <= irq_q;
      nmi_q    <= nmi_s2;
      mod_q    <= module_req; // [R15]
      if (nmi_event)
        nmi_pend <= 1'b1; // [R13]
      else if (clear_nmi)
        nmi_pend <= 1'b0;
    end
  end

  // ==========================================================
  // Priority selection: index order is the default order
  logic [SRC_N-1:0] src_pend;
  logic [4:0]       src_lvl [SRC_N];
  logic [7:0]       src_vec [SRC_N];
  logic [SRC_N-1:0] src_edge;

  always_comb
  begin
    src_pend[0] = nmi_pend;
    src_lvl[0]  = NMI_LEVEL;
    src_vec[0]  = NMI_VECTOR;
    src_edge[0] = 1'b1;
    for (int i = 0; i < IRQ_N; i++)
    begin
      src_pend[1+i] = irq_pend[i];
      src_lvl[1+i]  = {1'b0, field_level(5'(i))}; // [R21]
      src_vec[1+i]  = IRQ_VECTOR + 8'(i);
      src_edge[1+i] = sense_edge[i];
    end
    for (int m = 0; m < MOD_N; m++)
    begin
      src_pend[1+IRQ_N+m] = mod_q[m];
      src_lvl[1+IRQ_N+m]  = {1'b0, field_level(MOD_FIELD[m])}; // [R22]
      src_vec[1+IRQ_N+m]  = MOD_VECTOR + 8'(m);
      src_edge[1+IRQ_N+m] = 1'b0;
    end
  end

  iaa_accept_t      best;
  logic             best_valid;

  always_comb
  begin
    best       = '0;
    best_valid = 1'b0;
    for (int s = 0; s < SRC_N; s++)
    begin
      // Strictly greater keeps the earlier source on a tie
      if (src_pend[s] && (src_lvl[s] > best.level)) // [R1] [R2]
      begin
        best.level       = src_lvl[s];
        best.vector      = src_vec[s];
        best.idx         = 5'(s);
        best.edge_sensed = src_edge[s];
        best_valid       = 1'b1;
      end
    end
  end

  wire [3:0] mask_level_field = cpu_status_word[MASK_LSB +: 4];
  wire       accept_ok = best_valid && (best.level > {1'b0, mask_level_field}); // [R3]

  // One register stage after pending: 2 states on-chip, 3 from a pin
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cpu_request_out_pin_n <= 1'b1; // [R25]
      cand                  <= '0;
    end
    else
    begin
      // Falls when a higher request is present, rises once none exceeds mask
      cpu_request_out_pin_n <= ~accept_ok; // [R4] [R9] [R11] [R16]
      cand                  <= best;
    end
  end

  // Pin register is the CPU request line itself
  wire cpu_request = ~cpu_request_out_pin_n; // [R5]

  // ==========================================================
  // Exception entry sequencer
  wire [31:0] sr_slot  = cpu_stack_ptr - WORD_BYTES;
  wire [31:0] pc_slot  = cpu_stack_ptr - (WORD_BYTES + WORD_BYTES);
  wire [31:0] vec_addr = cpu_vector_base + {22'h0, acc.vector, 2'b00};
  wire        status_wr;
  wire [31:0] status_wdata;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state           <= IAA_IDLE;
      acc             <= '0;
      mem_req         <= '0;
      entry_branch    <= 1'b0;
      handler_addr    <= '0;
      stack_ptr_out   <= '0;
      cpu_status_word <= STATUS_RESET;
    end
    else
    begin
      entry_branch <= 1'b0;
      if (status_wr)
        cpu_status_word <= status_wdata;
      unique case (state)
        IAA_IDLE:
        begin
          // Busy sequencer defers the request to the next decode
          if (cpu_decode && cpu_request) // [R6] [R17]
          begin
            acc   <= cand;
            state <= IAA_REPLACE;
          end
        end
        IAA_REPLACE:
        begin
          mem_req <= '{valid: 1'b1, write: 1'b1, addr: sr_slot, wdata: cpu_status_word}; // [R7]
          state   <= IAA_SAVE_SR;
        end
        IAA_SAVE_SR:
        begin
          if (mem_ready)
          begin
            mem_req <= '{valid: 1'b1, write: 1'b1, addr: pc_slot, wdata: program_counter}; // [R7]
            state   <= IAA_SAVE_PC;
          end
        end
        IAA_SAVE_PC:
        begin
          if (mem_ready)
          begin
            cpu_status_word[MASK_LSB +: 4] <= acc.level[4] ? TOP_MASK : acc.level[3:0]; // [R8]
            mem_req <= '{valid: 1'b1, write: 1'b0, addr: vec_addr, wdata: 32'h0}; // [R12]
            state   <= IAA_VECTOR;
          end
        end
        IAA_VECTOR:
        begin
          if (mem_ready)
          begin
            mem_req      <= '0;
            handler_addr <= mem_rdata; // [R12]
            entry_branch <= 1'b1; // [R12] [R18]
            state        <= IAA_BRANCH;
          end
        end
        IAA_BRANCH:
        begin
          stack_ptr_out <= pc_slot;
          state         <= IAA_IDLE;
        end
        default:
        begin
          state <= IAA_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // AXI4-Lite slave
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  wire        do_write = aw_held && w_held && !s_axi_bvalid;
  wire [7:0]  wa       = aw_addr;
  wire        wa_level = (wa <= OFS_LEVEL_E) && (wa[1:0] == 2'b00);
  wire        wa_ok    = wa_level || (wa == OFS_SENSE) || (wa == OFS_PINFUNC) || (wa == OFS_STATUS)
                         || (wa == OFS_ACCEPT);
  wire [15:0] w_lo16   = {w_strb[1] ? w_data[15:8] : 8'h0, w_strb[0] ? w_data[7:0] : 8'h0};
  wire [15:0] w_keep16 = {{8{w_strb[1]}}, {8{w_strb[0]}}};
  wire [31:0] w_keep32 = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  assign status_wr    = do_write && (wa == OFS_STATUS) && (state == IAA_IDLE);
  assign status_wdata = (cpu_status_word & ~w_keep32) | (w_data & w_keep32);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held               <= 1'b0;
      w_held                <= 1'b0;
      aw_addr               <= '0;
      w_data                <= '0;
      w_strb                <= '0;
      s_axi_bvalid          <= 1'b0;
      s_axi_bresp           <= RESP_OKAY;
      pin_sense_control_reg <= SENSE_RESET;
      pin_function_selector <= PINFUNC_RESET;
      for (int r = 0; r < 5; r++)
        source_level_regs[r] <= LEVEL_RESET;
    end
    else
    begin
      if (s_axi_awvalid && !aw_held)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (do_write)
      begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wa_ok ? RESP_OKAY : RESP_DECERR;
        if (wa_level)
        begin
          source_level_regs[wa[4:2]] <= ((source_level_regs[wa[4:2]] & ~w_keep16) | w_lo16)
                                        & ((wa == OFS_LEVEL_E) ? LEVEL_E_MASK : 16'hffff);
        end
        if (wa == OFS_SENSE)
        begin
          if (w_strb[1])
            pin_sense_control_reg[NMI_EDGE_BIT] <= w_data[NMI_EDGE_BIT];
          if (w_strb[0])
            pin_sense_control_reg[7:0] <= w_data[7:0];
        end
        if ((wa == OFS_PINFUNC) && w_strb[0])
          pin_function_selector <= w_data[7:0]; // [R20]
      end
    end
  end

  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;

  // Read side: one request at a time, answer one cycle after acceptance
  wire [7:0]  ra       = s_axi_araddr;
  wire        ra_level = (ra <= OFS_LEVEL_E) && (ra[1:0] == 2'b00);
  wire [15:0] sense_rd = {nmi_q, 6'h0, pin_sense_control_reg[NMI_EDGE_BIT], pin_sense_control_reg[7:0]};
  wire [31:0] accept_rd = {8'h0, acc.vector, 3'h0, acc.level, 6'h0, state != IAA_IDLE, cpu_request};
  wire [31:0] rd_mux =
    ra_level              ? {16'h0, source_level_regs[ra[4:2]]} :
    (ra == OFS_SENSE)     ? {16'h0, sense_rd} :
    (ra == OFS_PINFUNC)   ? {24'h0, pin_function_selector} :
    (ra == OFS_STATUS)    ? cpu_status_word :
    (ra == OFS_ACCEPT)    ? accept_rd : 32'h0;
  wire        ra_ok = ra_level || (ra == OFS_SENSE) || (ra == OFS_PINFUNC) || (ra == OFS_STATUS)
                      || (ra == OFS_ACCEPT);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= ra_ok ? RESP_OKAY : RESP_DECERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// file: verilog/iaa_pkg.sv
// Constants, types and register layout of the interrupt accept arbiter.
// Assumes one 50 MHz clock; one CPU state is one clock cycle.
package iaa_pkg;

  // ==========================================================
  // Sizes
  localparam int IRQ_N   = 8;
  localparam int MOD_N   = 15;
  localparam int SRC_N   = 1 + IRQ_N + MOD_N;
  localparam int FIELD_N = 20;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_LEVEL_A  = 8'h00;
  localparam logic [7:0] OFS_LEVEL_E  = 8'h10;
  localparam logic [7:0] OFS_SENSE    = 8'h14;
  localparam logic [7:0] OFS_PINFUNC  = 8'h18;
  localparam logic [7:0] OFS_STATUS   = 8'h1c;
  localparam logic [7:0] OFS_ACCEPT   = 8'h20;

  // Field positions and reset values
  localparam int NMI_LEVEL_BIT = 15;
  localparam int NMI_EDGE_BIT  = 8;
  localparam int MASK_LSB      = 4;
  localparam logic [15:0] LEVEL_RESET   = 16'h0000;
  localparam logic [15:0] SENSE_RESET   = 16'h0000;
  localparam logic [7:0]  PINFUNC_RESET = 8'h00;
  localparam logic [31:0] STATUS_RESET  = 32'h000000f0;
  localparam logic [15:0] LEVEL_E_MASK  = 16'hfff0;

  // Levels: field values 0..15, nonmaskable above all of them
  localparam logic [4:0] NMI_LEVEL = 5'h10;
  localparam logic [3:0] TOP_MASK  = 4'hf;

  // Vector numbers (arbitrary placement)
  localparam logic [7:0] NMI_VECTOR = 8'h0b;
  localparam logic [7:0] IRQ_VECTOR = 8'h40;
  localparam logic [7:0] MOD_VECTOR = 8'h48;

  // Priority field of each on-chip request, index = default order
  localparam logic [4:0] MOD_FIELD [MOD_N] = '{
    5'h08, 5'h08, 5'h09, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d,
    5'h0e, 5'h0f, 5'h10, 5'h11, 5'h11, 5'h12, 5'h12};

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;

  // ==========================================================
  // Timing in CPU states
  localparam int CLK_PERIOD_NS   = 20;
  localparam int STATE_NS        = 20;
  localparam int STATE_CYCLES    = (STATE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SEL_STATES_CHIP = 2;
  localparam int SEL_STATES_PIN  = 3;
  localparam int ENTRY_STATES    = 5;
  localparam int MIN_RESP_CHIP   = 10;
  localparam int MIN_RESP_PIN    = 11;
  localparam logic [31:0] WORD_BYTES = 32'h00000004;

  // ==========================================================
  // Types
  typedef enum logic [5:0] {
    IAA_IDLE    = 6'b000001,
    IAA_REPLACE = 6'b000010,
    IAA_SAVE_SR = 6'b000100,
    IAA_SAVE_PC = 6'b001000,
    IAA_VECTOR  = 6'b010000,
    IAA_BRANCH  = 6'b100000
  } iaa_state_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } iaa_mem_req_t;

  typedef struct packed {
    logic [7:0] vector;
    logic [4:0] level;
    logic [4:0] idx;
    logic       edge_sensed;
  } iaa_accept_t;

endpackage
